// ### core/rf_ctrl_pkg.sv
// Register map, field layouts and state codes for the receive-mode / antenna-driver block
package rf_ctrl_pkg;
    // Byte addresses on the register bus
    localparam logic [15:0] ADDR_RX_MODE   = 16'h6300;
    localparam logic [15:0] ADDR_DRV_CTRL  = 16'h6304;
    localparam logic [15:0] ADDR_AUTO_TX   = 16'h6308;
    localparam logic [15:0] ADDR_COMMAND   = 16'h630c;
    localparam logic [15:0] ADDR_IRQ_STAT  = 16'h6310;
    localparam logic [15:0] ADDR_IRQ_MASK  = 16'h6314;
    localparam logic [15:0] ADDR_ERR_COPY  = 16'h6318;

    // Reset values
    localparam logic [7:0] RST_RX_MODE  = 8'h00;
    localparam logic [7:0] RST_DRV_CTRL = 8'h80;
    localparam logic [7:0] RST_AUTO_TX  = 8'h00;
    localparam logic [7:0] RST_COMMAND  = 8'h00;
    localparam logic [3:0] RST_IRQ      = 4'h0;

    // Receive rate codes
    localparam logic [2:0] RATE_106  = 3'h0;
    localparam logic [2:0] RATE_212  = 3'h1;
    localparam logic [2:0] RATE_424  = 3'h2;
    localparam logic [2:0] RATE_848  = 3'h3;
    localparam logic [2:0] RATE_1696 = 3'h4;
    localparam logic [2:0] RATE_3392 = 3'h5;

    // Receive framing codes
    localparam logic [1:0] FRAME_TYPE_A  = 2'h0;
    localparam logic [1:0] FRAME_ACTIVE  = 2'h1;
    localparam logic [1:0] FRAME_PASSIVE = 2'h2;
    localparam logic [1:0] FRAME_TYPE_B  = 2'h3;

    // Command field and the idle code
    localparam logic [3:0] CMD_IDLE       = 4'h0;
    localparam int         SHORT_FRAME_BITS = 4;

    // Interrupt status bit positions
    localparam int IRQ_FRAME_DONE = 0;
    localparam int IRQ_SHORT_DROP = 1;
    localparam int IRQ_ERR_BYTE   = 2;
    localparam int IRQ_EN_REFUSED = 3;

    typedef struct packed {
        logic       crcKeep;
        logic [2:0] receiveRateCode;
        logic       ignoreShortFrame;
        logic       multiFrameReceive;
        logic [1:0] receiveFramingSelect;
    } rx_mode_t;

    typedef struct packed {
        logic invertOutBWhenOn;
        logic invertOutAWhenOn;
        logic invertOutBWhenOff;
        logic invertOutAWhenOff;
        logic outBContinuousWave;
        logic externalFieldCheck;
        logic outBCarrierEnable;
        logic outACarrierEnable;
    } drv_ctrl_t;

    typedef enum logic [2:0] {
        RX_IDLE    = 3'b001,
        RX_LISTEN  = 3'b010,
        RX_ERRBYTE = 3'b100
    } rx_state_t;
endpackage

// ### core/antenna_driver_out.sv
// One antenna driver output: carrier gating, modulation and polarity
`timescale 1ns/1ps
module antenna_driver_out (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Carrier and modulation
    input  wire logic carrierIn,
    input  wire logic txModulate,
    // Settings
    input  wire logic carrierEnable,
    input  wire logic continuousWave,
    input  wire logic invertWhenOn,
    input  wire logic invertWhenOff,
    // Pin
    output logic      driverOut
);
    logic level;

    // Modulation is ignored in continuous-wave mode
    always_comb begin
        level = carrierEnable & carrierIn & (continuousWave | ~txModulate);
        if (carrierEnable) begin
            level = level ^ invertWhenOn;
        end else begin
            level = level ^ invertWhenOff;
        end
    end

    // Registered so the pin never glitches on setting changes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            driverOut <= 1'b0;
        end else begin
            driverOut <= level;
        end
    end
endmodule

// ### core/rx_stream_counter.sv
// Saturating bit counter for one received data stream
`timescale 1ns/1ps
module rx_stream_counter #(
    parameter int MIN_BITS = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Stream events
    input  wire logic bitStrobe,
    input  wire logic clearCount,
    // Result
    output logic      longEnough
);
    localparam int CW = $clog2(MIN_BITS + 1);
    localparam logic [CW-1:0] LIMIT = CW'(MIN_BITS);
    logic [CW-1:0] count_r;

    // Saturates so long streams never wrap back to short
    always_ff @(posedge clk) begin
        if (sys_rst || clearCount) begin
            count_r <= '0;
        end else if (bitStrobe && count_r != LIMIT) begin
            count_r <= count_r + CW'(1);
        end
    end

    assign longEnough = (count_r == LIMIT);
endmodule

// ### core/rf_rx_mode_tx_driver_ctrl.sv
// Receive-mode settings, receive session control and antenna-driver control
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
// Contract
// - Rate codes 010..101 select 424 to 3392 kbit/s; 110, 111 reserved.
// - Rate field is three bits; 000 is 106 and 001 is 212 kbit/s.
// - With ignore set, streams under four bits are dropped; receiver stays active.
// - Multi-frame off: receiver stops after one complete frame.
// - Multi-frame on: keep receiving frames; only valid at 212 and 424.
// - Multi-frame receive ends only by idle command or clearing the bit; the code also ends it at the next stream end once the rate leaves 212/424.
// - Multi-frame on: error register copy written to FIFO after each stream.
// - Framing field selects type A, active, passive 212/424 or type B.
// - Output inverted when its on-inversion bit and carrier enable are set.
// - Output inverted when its off-inversion bit set and carrier disabled.
// - Continuous-wave bit gives unmodulated carrier on output B.
// - Carrier enable gives carrier modulated by transmit data on that output.
// - Field check refuses setting carrier enables while external field present.
// - Blocking acts only with auto carrier bits; field-check bit is write-only.
module rf_rx_mode_tx_driver_ctrl (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [15:0]           wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // Receiver front end
    input  wire logic                  rxStart,
    input  wire logic                  rxBitValid,
    input  wire logic                  rxStreamEnd,
    input  wire logic [7:0]            receiveErrorReg,
    output logic                       rxActive,
    output logic                       rxDone,
    output logic [2:0]                 receiveRateCode,
    output logic [1:0]                 receiveFramingSelect,
    // FIFO write port for the error byte
    output logic                       fifoWrValid,
    output logic [7:0]                 fifoWrData,
    // Transmitter and antenna
    input  wire logic                  carrierIn,
    input  wire logic                  txModulate,
    input  wire logic                  externalField,
    output logic                       antennaDriverA,
    output logic                       antennaDriverB,
    // Interrupt
    output logic                       irq
);
    import rf_ctrl_pkg::*;

    rx_mode_t  rxMode_r;
    drv_ctrl_t drvCtrl_r;
    logic [7:0] autoTx_r;
    logic [7:0] command_r;
    logic       fieldCheck_r;
    logic [3:0] irqStat_r;
    logic [3:0] irqMask_r;
    logic       ack_r;
    logic [31:0] rdData_r;
    rx_state_t  rxState_r;
    rx_state_t  rxState_nxt;
    logic       rxDone_r;
    logic       errValid_r;
    logic [7:0] errData_r;

    logic busReq;
    logic wrStrobe;
    logic idleCmd;
    logic multiEff;
    logic longEnough;
    logic dropShort;
    logic frameEnd;
    logic refuseA;
    logic refuseB;
    logic [3:0] irqEvent;

    // Multi-frame receive is honoured only at the polling rates
    function automatic logic pollRate(input logic [2:0] code);
        return (code == RATE_212) || (code == RATE_424);
    endfunction

    // Address match helper, used by write and read decode
    function automatic logic hit(input logic [15:0] adr, input logic [15:0] reg_adr);
        return adr == reg_adr;
    endfunction

    // Bus handshake: one wait state, ack dropped the cycle after
    assign busReq   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wrStrobe = busReq & wb_we_i & wb_sel_i[0];
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdData_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= busReq;
        end
    end

    // Read mux; unmapped addresses read zero, field-check never reads back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_r <= '0;
        end else if (busReq && !wb_we_i) begin
            rdData_r <= '0;
            if (hit(wb_adr_i, ADDR_RX_MODE)) begin
                rdData_r[7:0] <= rxMode_r;
            end
            if (hit(wb_adr_i, ADDR_DRV_CTRL)) begin
                rdData_r[7:0] <= {drvCtrl_r[7:3], 1'b0, drvCtrl_r[1:0]};
            end
            if (hit(wb_adr_i, ADDR_AUTO_TX)) begin
                rdData_r[7:0] <= autoTx_r;
            end
            if (hit(wb_adr_i, ADDR_COMMAND)) begin
                rdData_r[7:0] <= command_r;
            end
            if (hit(wb_adr_i, ADDR_IRQ_STAT)) begin
                rdData_r[3:0] <= irqStat_r;
            end
            if (hit(wb_adr_i, ADDR_IRQ_MASK)) begin
                rdData_r[3:0] <= irqMask_r;
            end
            if (hit(wb_adr_i, ADDR_ERR_COPY)) begin
                rdData_r[7:0] <= receiveErrorReg;
            end
        end
    end

    // Receive mode register; reserved rate codes are stored as written
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxMode_r <= rx_mode_t'(RST_RX_MODE);
        end else if (wrStrobe && hit(wb_adr_i, ADDR_RX_MODE)) begin
            rxMode_r <= rx_mode_t'(wb_dat_i[7:0]);
        end
    end

    assign receiveRateCode      = rxMode_r.receiveRateCode;
    assign receiveFramingSelect = rxMode_r.receiveFramingSelect;

    // Enable set refused per output while field present and checking applies
    assign refuseA = wb_dat_i[0] & ~drvCtrl_r.outACarrierEnable & wb_dat_i[2]
                   & externalField & autoTx_r[0];
    assign refuseB = wb_dat_i[1] & ~drvCtrl_r.outBCarrierEnable & wb_dat_i[2]
                   & externalField & autoTx_r[1];

    // Driver control register; the check bit acts on the same write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drvCtrl_r    <= drv_ctrl_t'(RST_DRV_CTRL);
            fieldCheck_r <= 1'b0;
        end else if (wrStrobe && hit(wb_adr_i, ADDR_DRV_CTRL)) begin
            drvCtrl_r <= drv_ctrl_t'(wb_dat_i[7:0]);
            drvCtrl_r.externalFieldCheck <= 1'b0;
            fieldCheck_r <= wb_dat_i[2];
            if (refuseA) begin
                drvCtrl_r.outACarrierEnable <= 1'b0;
            end
            if (refuseB) begin
                drvCtrl_r.outBCarrierEnable <= 1'b0;
            end
        end
    end

    // Auto transmit register: only the auto carrier bits are used here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            autoTx_r <= RST_AUTO_TX;
        end else if (wrStrobe && hit(wb_adr_i, ADDR_AUTO_TX)) begin
            autoTx_r <= wb_dat_i[7:0];
        end
    end

    // Command register; the idle code stops a running receive
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            command_r <= RST_COMMAND;
        end else if (wrStrobe && hit(wb_adr_i, ADDR_COMMAND)) begin
            command_r <= wb_dat_i[7:0];
        end
    end

    assign idleCmd = wrStrobe & hit(wb_adr_i, ADDR_COMMAND) & (wb_dat_i[3:0] == CMD_IDLE);

    // Bit count of the current stream
    rx_stream_counter #(
        .MIN_BITS   (SHORT_FRAME_BITS)
    ) u_counter (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .bitStrobe  (rxBitValid && rxState_r == RX_LISTEN),
        .clearCount (rxStreamEnd || rxState_r != RX_LISTEN),
        .longEnough (longEnough)
    );

    assign multiEff  = rxMode_r.multiFrameReceive & pollRate(rxMode_r.receiveRateCode);
    assign dropShort = rxStreamEnd & rxMode_r.ignoreShortFrame & ~longEnough;
    assign frameEnd  = rxStreamEnd & ~dropShort;

    // Receive session sequencing
    always_comb begin
        rxState_nxt = rxState_r;
        case (rxState_r)
            RX_IDLE: begin
                if (rxStart && !idleCmd) begin
                    rxState_nxt = RX_LISTEN;
                end
            end
            RX_LISTEN: begin
                if (idleCmd) begin
                    rxState_nxt = RX_IDLE;
                end else if (frameEnd && multiEff) begin
                    rxState_nxt = RX_ERRBYTE;
                end else if (frameEnd) begin
                    rxState_nxt = RX_IDLE;
                end else if (!rxMode_r.multiFrameReceive && rxDone_r) begin
                    rxState_nxt = RX_IDLE;
                end
            end
            RX_ERRBYTE: begin
                if (idleCmd || !rxMode_r.multiFrameReceive) begin
                    rxState_nxt = RX_IDLE;
                end else begin
                    rxState_nxt = RX_LISTEN;
                end
            end
            default: rxState_nxt = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxState_r <= RX_IDLE;
        end else begin
            rxState_r <= rxState_nxt;
        end
    end

    // Done pulse marks the session end, whatever caused it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxDone_r <= 1'b0;
        end else begin
            rxDone_r <= (rxState_r != RX_IDLE) && (rxState_nxt == RX_IDLE);
        end
    end

    // Error byte follows each stream not dropped as short or met by an idle command in its end cycle, in multi-frame mode at the polling rates
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            errValid_r <= 1'b0;
            errData_r  <= '0;
        end else begin
            errValid_r <= (rxState_r == RX_LISTEN) && frameEnd && multiEff && !idleCmd;
            if (rxState_r == RX_LISTEN && frameEnd && multiEff) begin
                errData_r <= receiveErrorReg;
            end
        end
    end

    assign rxActive    = (rxState_r != RX_IDLE);
    assign rxDone      = rxDone_r;
    assign fifoWrValid = errValid_r;
    assign fifoWrData  = errData_r;

    // Sticky status, set wins over a write-one clear
    assign irqEvent[IRQ_FRAME_DONE] = rxDone_r;
    assign irqEvent[IRQ_SHORT_DROP] = (rxState_r == RX_LISTEN) & dropShort;
    assign irqEvent[IRQ_ERR_BYTE]   = errValid_r;
    assign irqEvent[IRQ_EN_REFUSED] = wrStrobe & hit(wb_adr_i, ADDR_DRV_CTRL) & (refuseA | refuseB);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStat_r <= RST_IRQ;
            irqMask_r <= RST_IRQ;
        end else begin
            if (wrStrobe && hit(wb_adr_i, ADDR_IRQ_STAT)) begin
                irqStat_r <= (irqStat_r & ~wb_dat_i[3:0]) | irqEvent;
            end else begin
                irqStat_r <= irqStat_r | irqEvent;
            end
            if (wrStrobe && hit(wb_adr_i, ADDR_IRQ_MASK)) begin
                irqMask_r <= wb_dat_i[3:0];
            end
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // Two instances of one driver module; A has no continuous-wave control
    antenna_driver_out u_drv_a (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .carrierIn      (carrierIn),
        .txModulate     (txModulate),
        .carrierEnable  (drvCtrl_r.outACarrierEnable),
        .continuousWave (1'b0),
        .invertWhenOn   (drvCtrl_r.invertOutAWhenOn),
        .invertWhenOff  (drvCtrl_r.invertOutAWhenOff),
        .driverOut      (antennaDriverA)
    );

    antenna_driver_out u_drv_b (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .carrierIn      (carrierIn),
        .txModulate     (txModulate),
        .carrierEnable  (drvCtrl_r.outBCarrierEnable),
        .continuousWave (drvCtrl_r.outBContinuousWave),
        .invertWhenOn   (drvCtrl_r.invertOutBWhenOn),
        .invertWhenOff  (drvCtrl_r.invertOutBWhenOff),
        .driverOut      (antennaDriverB)
    );

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_short_drop;
        rxState_r == RX_LISTEN && dropShort && !idleCmd |=> rxState_r == RX_LISTEN;
    endproperty
    a_short_drop: assert property (p_short_drop) else $error("short stream ended receive");

    property p_single_stop;
        rxState_r == RX_LISTEN && frameEnd && !multiEff |=> rxState_r == RX_IDLE && rxDone;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single frame did not stop");

    property p_multi_keep;
        rxState_r == RX_ERRBYTE && !idleCmd && rxMode_r.multiFrameReceive
            |=> rxState_r == RX_LISTEN;
    endproperty
    a_multi_keep: assert property (p_multi_keep) else $error("multi receive stopped");

    property p_idle_stop;
        idleCmd && rxActive |=> !rxActive;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("idle command ignored");

    property p_err_byte;
        rxState_r == RX_LISTEN && frameEnd && multiEff && !idleCmd
            |=> fifoWrValid && fifoWrData == $past(receiveErrorReg);
    endproperty
    a_err_byte: assert property (p_err_byte) else $error("error byte missing");

    property p_inv_on;
        drvCtrl_r.outACarrierEnable && drvCtrl_r.invertOutAWhenOn && !carrierIn
            |=> antennaDriverA;
    endproperty
    a_inv_on: assert property (p_inv_on) else $error("output A not inverted on");

    property p_inv_off;
        !drvCtrl_r.outBCarrierEnable |=> antennaDriverB == $past(drvCtrl_r.invertOutBWhenOff);
    endproperty
    a_inv_off: assert property (p_inv_off) else $error("output B off level wrong");

    property p_cw;
        drvCtrl_r.outBCarrierEnable && drvCtrl_r.outBContinuousWave && carrierIn
            && !drvCtrl_r.invertOutBWhenOn |=> antennaDriverB;
    endproperty
    a_cw: assert property (p_cw) else $error("continuous wave modulated");

    property p_mod;
        drvCtrl_r.outACarrierEnable && carrierIn && txModulate
            && !drvCtrl_r.invertOutAWhenOn |=> !antennaDriverA;
    endproperty
    a_mod: assert property (p_mod) else $error("modulation not applied");

    property p_refuse;
        wrStrobe && hit(wb_adr_i, ADDR_DRV_CTRL) && refuseA
            |=> !drvCtrl_r.outACarrierEnable ##1 irqStat_r[IRQ_EN_REFUSED];
    endproperty
    a_refuse: assert property (p_refuse) else $error("enable set with field");

    c_multi:  cover property (fifoWrValid ##[1:50] fifoWrValid);
    c_short:  cover property (irqEvent[IRQ_SHORT_DROP]);
    c_refuse: cover property (irqEvent[IRQ_EN_REFUSED]);
endmodule

// ### bench/rf_far_side.sv
// Far-side model: remote card bit streams and the carrier source
`timescale 1ns/1ps
module rf_far_side (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sysRst,
    // Frame request
    input  wire logic       sendReq,
    input  wire logic [3:0] nBits,
    // Toward the block
    output logic            carrierIn,
    output logic            rxBitValid,
    output logic            rxStreamEnd,
    output logic            busy
);
    logic [4:0] cnt;

    // Carrier toggles each cycle so both levels reach the drivers
    always_ff @(posedge clk) begin
        carrierIn <= sysRst ? 1'b0 : ~carrierIn;
    end

    // One stream: nBits bit strobes, then the end strobe
    always_ff @(posedge clk) begin
        rxBitValid  <= 1'b0;
        rxStreamEnd <= 1'b0;
        if (sysRst) begin
            cnt <= 5'h00;
        end else if (sendReq && cnt == 5'h00) begin
            cnt <= {1'b0, nBits} + 5'h01;
        end else if (cnt > 5'h01) begin
            rxBitValid <= 1'b1;
            cnt        <= cnt - 5'h01;
        end else if (cnt == 5'h01) begin
            rxStreamEnd <= 1'b1;
            cnt         <= 5'h00;
        end
    end

    assign busy = (cnt != 5'h00) | rxBitValid | rxStreamEnd;
endmodule

// ### bench/rf_rx_mode_tx_driver_ctrl_test.sv
// Self-checking bench for the receive-mode and antenna-driver block
`timescale 1ns/1ps
module rf_rx_mode_tx_driver_ctrl_test;
    import rf_ctrl_pkg::*;
    logic        clk, sysRst, cyc, stb, we, ack, rxStart, rxAct, rxDone, fifoV;
    logic        bitV, strEnd, car, txMod, extFld, drvA, drvB, irq, sendReq, busy;
    logic [15:0] adr;
    logic [31:0] datI, datO;
    logic [7:0]  errReg, fifoD, rd, lastByte, rxm;
    logic [3:0]  nBits;
    logic [2:0]  rate;
    logic [1:0]  frm;
    logic [8:0]  dCase [6] = '{9'h080, 9'h003, 9'h103, 9'h10b, 9'h0c3, 9'h030};
    int          errCount = 0, testsRun = 0, cycles = 0, doneCnt = 0, fifoCnt = 0;

    rf_rx_mode_tx_driver_ctrl uut (
        .clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(datI), .wb_sel_i(4'hf), .wb_dat_o(datO), .wb_ack_o(ack),
        .rxStart(rxStart), .rxBitValid(bitV), .rxStreamEnd(strEnd),
        .receiveErrorReg(errReg), .rxActive(rxAct), .rxDone(rxDone),
        .receiveRateCode(rate), .receiveFramingSelect(frm), .fifoWrValid(fifoV),
        .fifoWrData(fifoD), .carrierIn(car), .txModulate(txMod), .externalField(extFld),
        .antennaDriverA(drvA), .antennaDriverB(drvB), .irq(irq)
    );
    rf_far_side far (
        .clk(clk), .sysRst(sysRst), .sendReq(sendReq), .nBits(nBits),
        .carrierIn(car), .rxBitValid(bitV), .rxStreamEnd(strEnd), .busy(busy)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulse counters; single-cycle pulses are easy to miss otherwise
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rxDone === 1'b1) doneCnt <= doneCnt + 1;
        if (fifoV === 1'b1) fifoCnt <= fifoCnt + 1;
        if (fifoV === 1'b1) lastByte <= fifoD;
        if (cycles == 5000) begin
            errCount++;
            endOfTest;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic endOfTest;
        $display("Checks %0d, mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Classic cycle; request held until ack is sampled at an edge
    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datI <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        rd = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        check(rd, exp);
    endtask

    // Expected pin level from the values sampled at the same edge
    task automatic drvChk(input logic [7:0] c, input logic m);
        logic ea;
        logic eb;
        wb(1'b1, ADDR_DRV_CTRL, c);
        txMod <= m;
        @(posedge clk);
        repeat (4) begin
            ea = (c[0] & car & ~m) ^ (c[0] ? c[6] : c[4]);
            eb = (c[1] & car & (c[3] | ~m)) ^ (c[1] ? c[7] : c[5]);
            @(posedge clk);
            check(drvA, ea);
            check(drvB, eb);
        end
    endtask

    task automatic rxGo;
        rxStart <= 1'b1;
        @(posedge clk);
        rxStart <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // One stream from the far side, then a short settle
    task automatic frame(input logic [3:0] n);
        int k;
        k = 0;
        sendReq <= 1'b1;
        nBits   <= n;
        @(posedge clk);
        sendReq <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        repeat (4) @(posedge clk);
    endtask

    // Main sequence
    initial begin
        sysRst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 16'h0000;
        datI = 32'h0; rxStart = 1'b0; errReg = 8'h00; txMod = 1'b0;
        extFld = 1'b0; sendReq = 1'b0; nBits = 4'h0;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        rdChk(ADDR_DRV_CTRL, RST_DRV_CTRL);
        rdChk(ADDR_RX_MODE, RST_RX_MODE);
        rdChk(16'h6340, 8'h00);
        // Legal rate codes only; the reserved ones are left out
        for (int i = 0; i < 6; i++) begin
            rxm = {1'b0, i[2:0], 2'b00, i[1:0]};
            wb(1'b1, ADDR_RX_MODE, rxm);
            check(rate, i[2:0]);
            check(frm, i[1:0]);
            rdChk(ADDR_RX_MODE, rxm);
        end
        foreach (dCase[i]) drvChk(dCase[i][7:0], dCase[i][8]);
        // Enable refused under a field with auto bits set
        extFld <= 1'b1;
        wb(1'b1, ADDR_AUTO_TX, 8'h03);
        wb(1'b1, ADDR_DRV_CTRL, 8'h07);
        rdChk(ADDR_DRV_CTRL, 8'h00);
        check(irq, 1'b0);
        rdChk(ADDR_IRQ_STAT, 8'h08);
        wb(1'b1, ADDR_IRQ_MASK, 8'h08);
        check(irq, 1'b1);
        wb(1'b1, ADDR_IRQ_STAT, 8'h08);
        check(irq, 1'b0);
        wb(1'b1, ADDR_AUTO_TX, 8'h00);
        wb(1'b1, ADDR_DRV_CTRL, 8'h07);
        rdChk(ADDR_DRV_CTRL, 8'h03);
        extFld <= 1'b0;
        wb(1'b1, ADDR_IRQ_MASK, 8'h00);
        // Single frame at 212 with short streams ignored
        wb(1'b1, ADDR_RX_MODE, 8'h18);
        rxGo;
        frame(4'h3);
        check(rxAct, 1'b1);
        check(8'(doneCnt), 8'h00);
        frame(4'h4);
        check(rxAct, 1'b0);
        check(8'(doneCnt), 8'h01);
        // Multi-frame at 424: error byte per stream, idle command stops
        errReg <= 8'h5a;
        wb(1'b1, ADDR_RX_MODE, 8'h24);
        rxGo;
        frame(4'h8);
        check(lastByte, 8'h5a);
        check(rxAct, 1'b1);
        errReg <= 8'ha5;
        frame(4'h8);
        check(lastByte, 8'ha5);
        check(8'(fifoCnt), 8'h02);
        check(rxAct, 1'b1);
        wb(1'b1, ADDR_COMMAND, {4'h0, CMD_IDLE});
        repeat (3) @(posedge clk);
        check(rxAct, 1'b0);
        check(8'(doneCnt), 8'h02);
        // Multi bit at 106 acts as single frame
        wb(1'b1, ADDR_RX_MODE, 8'h04);
        rxGo;
        frame(4'h8);
        check(rxAct, 1'b0);
        check(8'(fifoCnt), 8'h02);
        rdChk(ADDR_IRQ_STAT, 8'h07);
        endOfTest;
    end
endmodule
